// file: hdl/fps_pkg.sv
// Package of constants and types for the flash program sequencer
// Behaviour
// - Unlock: dummy control write, data-equals-address write, 10 us.
// - Control register write alone never starts a pulse.
// - Bit 0 enables writes; bit 1 low selects programming.
// - Bits 6:5 pick pulse width, in CPU clocks.
// - Bit 7 selects 32-bit doubleword programming.
// - Bit 15 holds writing mode until cleared.
// - Bit 4 reads the supply margin status.
// - Second write to same doubleword starts programming.
// - Bit 2 reads one while a pulse runs.
// - Pulse end enters program-verify mode automatically.
// - Supply loss during pulse sets sticky failure flag.
// - Clearing write enable returns to non-verify mode.
// - Clearing stay bit together with write enable returns to standard mode.
// - Control register moves only as whole 16-bit word.
// - Control register answers at any even flash address.
package fps_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int TMR_W = 18;

   // Control register field positions
   localparam int BIT_WRITE_EN = 0;
   localparam int BIT_ERASE_SEL = 1;
   localparam int BIT_BUSY = 2;
   localparam int BIT_SUPPLY_FAIL = 3;
   localparam int BIT_MARGIN_OK = 4;
   localparam int PW_LSB = 5;
   localparam int BIT_DWORD = 7;
   localparam int BIT_STAY = 15;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CTRL_WR_MASK = 16'h80E3;

   // Flash window, byte addresses
   localparam logic [ADDR_W-1:0] FLASH_FIRST = 18'h10000;
   localparam logic [ADDR_W-1:0] FLASH_LAST = 18'h17FFF;

   // Timing: times in their own unit, cycles derived (least times round up)
   localparam int CLK_PERIOD_PS = 5000;
   localparam int UNLOCK_WAIT_NS = 10000;
   localparam int VERIFY_SETTLE_NS = 4000;
   localparam int UNLOCK_CYC = (UNLOCK_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int VERIFY_CYC = (VERIFY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Pulse width scales with the CPU clock: 100 us at 20 MHz is a fixed clock count
   localparam int PW_REF_US = 100;
   localparam int PW_REF_MHZ = 20;
   localparam int PW01_CYC = PW_REF_US * PW_REF_MHZ;

   typedef enum logic [2:0] {
      FPS_STD    = 3'b000,
      FPS_ARMED  = 3'b001,
      FPS_SETTLE = 3'b010,
      FPS_WRMODE = 3'b011,
      FPS_HALF   = 3'b100,
      FPS_BUSY   = 3'b101
   } fps_state_t;

   // CPU access towards the flash window
   typedef struct packed {
      logic valid;
      logic write;
      logic indirect;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } fps_acc_t;

   // Answer to the CPU
   typedef struct packed {
      logic ack;
      logic trusted;
      logic [DATA_W-1:0] data;
   } fps_rsp_t;

   // Command to the cell array
   typedef struct packed {
      logic pulse;
      logic [1:0] lanes;
      logic [ADDR_W-3:0] dw_addr;
      logic [2*DATA_W-1:0] data;
   } fps_prog_t;

endpackage

// file: hdl/fps_sync3.sv
// Three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
module fps_sync3 (
   input wire logic clock_i, // CPU clock
   input wire logic rst_ni,  // Synchronised reset, active low
   input wire logic pin_i,   // Asynchronous level
   output logic level_o      // Filtered level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // First stage feeds only the second stage
   always_ff @(posedge clock_i or negedge rst_ni) begin
      if (!rst_ni) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts once stages two and three agree
   always_ff @(posedge clock_i or negedge rst_ni) begin
      if (!rst_ni) begin
         level_o <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_o <= s3_q;
      end
   end
endmodule

// file: hdl/fps_timer.sv
// Down counter shared by the unlock wait, the pulse and the verify settle
`timescale 1ns/1ps
module fps_timer
   import fps_pkg::*;
(
   input wire logic clock_i,                 // CPU clock
   input wire logic rst_ni,                  // Synchronised reset, active low
   input wire logic load_i,                  // Start a new interval
   input wire logic [fps_pkg::TMR_W-1:0] cycles_i, // Interval length in cycles
   output logic run_o,                       // Interval in progress
   output logic done_o                       // One-cycle pulse at the end
);
   logic [TMR_W-1:0] cnt_q;

   // A load restarts the count even if one is running
   always_ff @(posedge clock_i or negedge rst_ni) begin
      if (!rst_ni) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= cycles_i;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign run_o = (cnt_q != '0);
   assign done_o = (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1}) && !load_i;
endmodule

// file: hdl/fps_top.sv
// Flash program sequencer: unlock, control register, pulse timing, verify reads
`timescale 1ns/1ps
module fps_top #(
   parameter int PW00_CYC = 1000,                 // Pulse code 00, cycles
   parameter int PW01_CYCLES = fps_pkg::PW01_CYC, // Pulse code 01, cycles
   parameter int PW10_CYC = 4000,                 // Pulse code 10, cycles
   parameter int PW11_CYC = 200000,               // Pulse code 11, cycles
   parameter int UNLOCK_CYCLES = fps_pkg::UNLOCK_CYC, // Unlock wait, cycles
   parameter int VERIFY_CYCLES = fps_pkg::VERIFY_CYC  // Verify settle, cycles
) (
   input wire logic clock_i,                        // CPU clock, 200 MHz
   input wire logic rstn_i,                         // Reset, active low, async
   input wire fps_pkg::fps_acc_t acc_i,             // CPU access to flash window
   output fps_pkg::fps_rsp_t rsp_o,                 // Answer one cycle later
   output logic [fps_pkg::ADDR_W-1:0] array_addr_o, // Read address to the cells
   input wire logic [fps_pkg::DATA_W-1:0] array_rdata_i, // Cell read data
   input wire logic supply_ok_i,                    // Programming supply in margin, pin
   output fps_pkg::fps_prog_t prog_o,               // Programming command to cells
   output logic check_margin_o,                     // Program-check margin applied
   output logic writing_mode_o                      // Writing mode entered
);
   import fps_pkg::*;

   // Refuse sizes the timer cannot hold
   if (PW00_CYC < 1 || PW01_CYCLES < 1 || PW10_CYC < 1 || PW11_CYC < 1 ||
       PW11_CYC >= (1 << TMR_W) || PW10_CYC >= (1 << TMR_W) ||
       PW00_CYC >= (1 << TMR_W) || PW01_CYCLES >= (1 << TMR_W) ||
       UNLOCK_CYCLES < 1 || UNLOCK_CYCLES >= (1 << TMR_W) ||
       VERIFY_CYCLES < 1 || VERIFY_CYCLES >= (1 << TMR_W)) begin : g_chk
      $error("fps_top: cycle count out of timer range");
   end

   logic [1:0] rst_q;
   logic rst_n;
   fps_state_t state_q;
   logic [DATA_W-1:0] ctrl_q;
   logic fail_q;
   logic check_q;
   logic vfy_pend_q;
   logic [ADDR_W-1:0] vfy_addr_q;
   logic supply_ok;
   logic tmr_load;
   logic [TMR_W-1:0] tmr_cycles;
   logic tmr_run;
   logic tmr_done;
   logic in_range;
   logic ctrl_wr;
   logic ctrl_rd;
   logic cell_wr;
   logic cell_rd;
   logic unlock_hit;
   logic prog_en;
   logic pulse_start;
   logic same_dword;
   logic vfy_first;
   logic vfy_second;
   logic [DATA_W-1:0] ctrl_view;
   logic [ADDR_W-3:0] half_dw_q;
   fps_prog_t prog_q;
   fps_rsp_t rsp_q;

   // Cycle count for a pulse-width code
   function automatic logic [TMR_W-1:0] pw_cycles(input logic [1:0] code);
      logic [TMR_W-1:0] r;
      r = '0;
      case (code)
         2'b00: r = TMR_W'(PW00_CYC);
         2'b01: r = TMR_W'(PW01_CYCLES);
         2'b10: r = TMR_W'(PW10_CYC);
         default: r = TMR_W'(PW11_CYC);
      endcase
      return r;
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // Supply pin comes from outside the clock domain
   fps_sync3 u_supply (
      .clock_i(clock_i),
      .rst_ni(rst_n),
      .pin_i(supply_ok_i),
      .level_o(supply_ok)
   );

   // One timer serves all intervals; they never overlap
   fps_timer u_timer (
      .clock_i(clock_i),
      .rst_ni(rst_n),
      .load_i(tmr_load),
      .cycles_i(tmr_cycles),
      .run_o(tmr_run),
      .done_o(tmr_done)
   );

   // Access decode: direct even addresses hit the control register, indirect hit cells
   assign in_range = acc_i.valid && (acc_i.addr >= FLASH_FIRST) && (acc_i.addr <= FLASH_LAST);
   assign ctrl_wr = in_range && !acc_i.indirect && !acc_i.addr[0] && acc_i.write;
   assign ctrl_rd = in_range && !acc_i.indirect && !acc_i.addr[0] && !acc_i.write;
   assign cell_wr = in_range && acc_i.indirect && acc_i.write;
   assign cell_rd = in_range && acc_i.indirect && !acc_i.write;
   assign unlock_hit = cell_wr && (acc_i.wdata == acc_i.addr[DATA_W-1:0]);
   assign prog_en = ctrl_q[BIT_WRITE_EN] && !ctrl_q[BIT_ERASE_SEL];
   assign same_dword = (acc_i.addr[ADDR_W-1:2] == half_dw_q);

   // A pulse starts only from a cell write, never from a control write
   always_comb begin
      pulse_start = 1'b0;
      case (state_q)
         FPS_WRMODE: pulse_start = cell_wr && prog_en && !ctrl_q[BIT_DWORD];
         FPS_HALF: pulse_start = cell_wr && same_dword;
         default: pulse_start = 1'b0;
      endcase
   end

   // Verify reads: first read arms the settle time, a matching later read is trusted
   assign vfy_second = check_q && cell_rd && vfy_pend_q && (acc_i.addr == vfy_addr_q) && !tmr_run;
   assign vfy_first = check_q && cell_rd && !vfy_second;

   // Timer load selection
   always_comb begin
      tmr_load = 1'b0;
      tmr_cycles = '0;
      if (state_q == FPS_ARMED && unlock_hit) begin
         tmr_load = 1'b1;
         tmr_cycles = TMR_W'(UNLOCK_CYCLES);
      end else if (pulse_start) begin
         tmr_load = 1'b1;
         tmr_cycles = pw_cycles(ctrl_q[PW_LSB +: 2]);
      end else if (vfy_first && state_q == FPS_WRMODE) begin
         tmr_load = 1'b1;
         tmr_cycles = TMR_W'(VERIFY_CYCLES);
      end
   end

   // Mode sequencing
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FPS_STD;
      end else begin
         case (state_q)
            FPS_STD: begin
               if (ctrl_wr) begin
                  state_q <= FPS_ARMED;
               end
            end
            FPS_ARMED: begin
               // Any flash-window access other than the key write breaks the sequence
               if (unlock_hit) begin
                  state_q <= FPS_SETTLE;
               end else if (in_range) begin
                  state_q <= FPS_STD;
               end
            end
            FPS_SETTLE: begin
               if (tmr_done) begin
                  state_q <= FPS_WRMODE;
               end
            end
            FPS_WRMODE: begin
               if (ctrl_wr && !acc_i.wdata[BIT_WRITE_EN] && !acc_i.wdata[BIT_STAY]) begin
                  state_q <= FPS_STD;
               end else if (pulse_start) begin
                  state_q <= FPS_BUSY;
               end else if (cell_wr && prog_en && ctrl_q[BIT_DWORD]) begin
                  state_q <= FPS_HALF;
               end
            end
            FPS_HALF: begin
               // The next flash-window access must be the matching write; any other one drops the half word
               if (pulse_start) begin
                  state_q <= FPS_BUSY;
               end else if (in_range) begin
                  state_q <= FPS_WRMODE;
               end
            end
            FPS_BUSY: begin
               if (tmr_done) begin
                  state_q <= FPS_WRMODE;
               end
            end
            default: state_q <= FPS_STD;
         endcase
      end
   end

   // Control register: written whole, only in writing mode outside a pulse
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (ctrl_wr && state_q == FPS_WRMODE) begin
         ctrl_q <= acc_i.wdata & CTRL_WR_MASK;
      end
   end

   // Supply failure is sticky; write one to clear, a new failure wins
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         fail_q <= 1'b0;
      end else if (state_q == FPS_BUSY && !supply_ok) begin
         fail_q <= 1'b1;
      end else if (ctrl_wr && state_q == FPS_WRMODE && acc_i.wdata[BIT_SUPPLY_FAIL]) begin
         fail_q <= 1'b0;
      end
   end

   // Program-check mode follows each pulse end until write enable drops or a cell write comes
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         check_q <= 1'b0;
      end else if (state_q == FPS_BUSY && tmr_done) begin
         check_q <= 1'b1;
      end else if (ctrl_wr && state_q == FPS_WRMODE && !acc_i.wdata[BIT_WRITE_EN]) begin
         check_q <= 1'b0;
      end else if (pulse_start || (cell_wr && state_q == FPS_WRMODE) || state_q == FPS_STD) begin
         check_q <= 1'b0;
      end
   end

   // Verify read tracking
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         vfy_pend_q <= 1'b0;
         vfy_addr_q <= '0;
      end else if (!check_q) begin
         vfy_pend_q <= 1'b0;
      end else if (vfy_second) begin
         vfy_pend_q <= 1'b0;
      end else if (vfy_first) begin
         vfy_pend_q <= 1'b1;
         vfy_addr_q <= acc_i.addr;
      end
   end

   // Programming command: first doubleword write is the low word
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         prog_q <= '0;
         half_dw_q <= '0;
      end else begin
         prog_q.pulse <= (state_q == FPS_BUSY && !tmr_done) || pulse_start;
         if (state_q == FPS_WRMODE && cell_wr && prog_en) begin
            half_dw_q <= acc_i.addr[ADDR_W-1:2];
            prog_q.dw_addr <= acc_i.addr[ADDR_W-1:2];
            if (ctrl_q[BIT_DWORD]) begin
               prog_q.data[DATA_W-1:0] <= acc_i.wdata;
               prog_q.lanes <= 2'b11;
            end else if (acc_i.addr[1]) begin
               prog_q.data[2*DATA_W-1:DATA_W] <= acc_i.wdata;
               prog_q.lanes <= 2'b10;
            end else begin
               prog_q.data[DATA_W-1:0] <= acc_i.wdata;
               prog_q.lanes <= 2'b01;
            end
         end else if (state_q == FPS_HALF && pulse_start) begin
            prog_q.data[2*DATA_W-1:DATA_W] <= acc_i.wdata;
         end
      end
   end

   // Status view of the control register
   always_comb begin
      ctrl_view = ctrl_q;
      ctrl_view[BIT_BUSY] = (state_q == FPS_BUSY);
      ctrl_view[BIT_SUPPLY_FAIL] = fail_q;
      ctrl_view[BIT_MARGIN_OK] = supply_ok;
   end

   // Answers: cells are unreadable in programming mode except through verify
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= '0;
      end else begin
         rsp_q.ack <= in_range;
         rsp_q.trusted <= vfy_second;
         if (ctrl_rd) begin
            rsp_q.data <= ctrl_view;
         end else if (cell_rd && (check_q || !prog_en || state_q == FPS_STD)) begin
            rsp_q.data <= array_rdata_i;
         end else begin
            rsp_q.data <= '0;
         end
      end
   end

   assign rsp_o = rsp_q;
   assign prog_o = prog_q;
   assign array_addr_o = acc_i.addr;
   assign check_margin_o = check_q;
   assign writing_mode_o = (state_q == FPS_WRMODE) || (state_q == FPS_HALF) || (state_q == FPS_BUSY);
endmodule

// file: verification/flash_program_sequencer_bench.sv
// Self-checking bench for the flash program sequencer
`timescale 1ns/1ps
module flash_program_sequencer_bench;
   import fps_pkg::*;
   localparam int UNL = 20;
   localparam int VER = 10;
   localparam logic [17:0] CR = 18'h10000;
   localparam logic [17:0] DW = 18'h10040;
   localparam logic [15:0] LO = 16'hA5C3;
   localparam logic [15:0] HI = 16'h3C5A;
   int pw [4] = '{10, 20, 30, 50};
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic supply_ok_i = 1'b1;
   fps_acc_t acc = '0;
   fps_rsp_t rsp;
   fps_prog_t prog;
   logic [17:0] aaddr;
   logic [15:0] ardata, got;
   logic check_margin, writing_mode, ack_seen, tr;
   int mismatches = 0;
   int comparisons = 0;
   int n;
   int pulses = 0;

   // 200 MHz clock
   always #2.5 clock_i = ~clock_i;

   // Count pulse starts; every cell here is pulsed once
   always @(posedge prog.pulse) pulses++;

   // Short pulse, unlock and settle counts keep the run brief
   fps_top #(.PW00_CYC(10), .PW01_CYCLES(20), .PW10_CYC(30), .PW11_CYC(50), .UNLOCK_CYCLES(UNL),
      .VERIFY_CYCLES(VER)) dut (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .acc_i(acc),
      .rsp_o(rsp),
      .array_addr_o(aaddr),
      .array_rdata_i(ardata),
      .supply_ok_i(supply_ok_i),
      .prog_o(prog),
      .check_margin_o(check_margin),
      .writing_mode_o(writing_mode)
   );
   fps_cell_model cells (.clock_i(clock_i), .prog_i(prog), .addr_i(aaddr), .rdata_o(ardata));

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   // One access held for one edge; an idle edge always precedes it
   task automatic access(input logic w, input logic ind, input logic [17:0] a, input logic [15:0] d);
      @(posedge clock_i);
      #1;
      acc = '{1'b1, w, ind, a, d};
      @(posedge clock_i);
      #1;
      acc.valid = 1'b0;
      {ack_seen, tr, got} = rsp;
   endtask

   // Two cell writes on consecutive edges, valid held between them
   task automatic dword(input logic [17:0] a, input logic [15:0] lo, input logic [15:0] hi);
      @(posedge clock_i);
      #1;
      acc = '{1'b1, 1'b1, 1'b1, a, lo};
      @(posedge clock_i);
      #1;
      check(prog.pulse, 1'b0);
      acc.wdata = hi;
      @(posedge clock_i);
      #1;
      acc.valid = 1'b0;
   endtask

   task automatic ctrl_is(input logic [15:0] e);
      access(1'b0, 1'b0, CR, 16'h0000);
      check(got, e);
   endtask

   // Poll the control word until the pulse is over, bounded
   task automatic wait_idle;
      int i;
      for (i = 0; i < 400; i++) begin
         access(1'b0, 1'b0, CR, 16'h0000);
         if (got[2] === 1'b0) break;
      end
      check(i < 400, 1'b1);
   endtask

   // First read only starts the margin settle; the second is the valid one
   task automatic vread(input logic [17:0] a, input logic [15:0] e);
      access(1'b0, 1'b1, a, 16'h0000);
      check(tr, 1'b0);
      repeat (VER + 2) @(posedge clock_i);
      access(1'b0, 1'b1, a, 16'h0000);
      check({tr, got}, {1'b1, e});
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // The whole run takes a few hundred cycles; this cuts a hang short
   initial begin
      #100000;
      mismatches++;
      summarize;
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      // Margin bit shows only once the internal reset and the pin filter have settled
      repeat (8) @(posedge clock_i);
      ctrl_is(16'h0010);
      check(ack_seen, 1'b1);
      access(1'b0, 1'b0, 18'h00100, 16'h0000);
      check(ack_seen, 1'b0);
      // Control write in standard mode only arms; a read disarms it
      access(1'b1, 1'b0, CR, 16'h80A1);
      ctrl_is(16'h0010);
      access(1'b1, 1'b0, CR, 16'h0000);
      access(1'b1, 1'b1, DW, 16'h1234);
      repeat (UNL + 5) @(posedge clock_i);
      check(writing_mode, 1'b0);
      access(1'b1, 1'b0, CR, 16'h0000);
      access(1'b1, 1'b1, DW, DW[15:0]);
      repeat (UNL - 4) @(posedge clock_i);
      check(writing_mode, 1'b0);
      repeat (8) @(posedge clock_i);
      check(writing_mode, 1'b1);
      // Mode setup at the top even address prepares but never pulses
      access(1'b1, 1'b0, 18'h17FFE, 16'h80A1);
      repeat (4) @(posedge clock_i);
      check(prog.pulse, 1'b0);
      access(1'b1, 1'b0, CR + 18'h1, 16'h0000);
      check(ack_seen, 1'b1);
      ctrl_is(16'h80B1);
      dword(DW, LO, HI);
      check({prog.pulse, prog.lanes, prog.dw_addr, prog.data}, {1'b1, 2'b11, DW[17:2], HI, LO});
      ctrl_is(16'h80B5);
      access(1'b1, 1'b1, DW + 18'h4, 16'h5555);
      check(prog.data, {HI, LO});
      wait_idle;
      check(check_margin, 1'b1);
      vread(DW, LO);
      vread(DW + 18'h2, HI);
      // Erase select set: a cell write must not start a programming pulse
      access(1'b1, 1'b0, CR, 16'h8003);
      access(1'b1, 1'b1, DW + 18'h30, 16'h0F0F);
      check(prog.pulse, 1'b0);
      // Every pulse width code in word mode
      for (int c = 0; c < 4; c++) begin
         access(1'b1, 1'b0, CR, 16'h8001 | (16'(c) << 5));
         access(1'b1, 1'b1, DW + 18'h8 + 18'(4 * c), 16'h0F00);
         check(prog.lanes, 2'b01);
         n = 0;
         while (prog.pulse === 1'b1 && n < 1000) begin
            n++;
            @(posedge clock_i);
            #1;
         end
         check(n, pw[c]);
      end
      // Supply loss mid-pulse latches the failure flag until written with one
      access(1'b1, 1'b0, CR, 16'h8061);
      access(1'b1, 1'b1, DW + 18'h20, 16'h00FF);
      supply_ok_i = 1'b0;
      repeat (10) @(posedge clock_i);
      #1;
      supply_ok_i = 1'b1;
      wait_idle;
      repeat (8) @(posedge clock_i);
      ctrl_is(16'h8079);
      access(1'b1, 1'b0, CR, 16'h8069);
      ctrl_is(16'h8071);
      // Leave programming, then leave writing mode
      access(1'b1, 1'b0, CR, 16'h8000);
      repeat (2) @(posedge clock_i);
      check({check_margin, writing_mode}, 2'b01);
      access(1'b0, 1'b1, DW, 16'h0000);
      check(got, LO);
      access(1'b1, 1'b0, CR, 16'h0000);
      repeat (2) @(posedge clock_i);
      check(writing_mode, 1'b0);
      ctrl_is(16'h0010);
      check(pulses, 6);
      summarize;
   end
endmodule

bind fps_top fps_top_props props (.clock_i(clock_i), .rstn_i(rstn_i), .acc_i(acc_i), .rsp_o(rsp_o),
   .array_addr_o(array_addr_o), .array_rdata_i(array_rdata_i), .supply_ok_i(supply_ok_i), .prog_o(prog_o),
   .check_margin_o(check_margin_o), .writing_mode_o(writing_mode_o));

// file: verification/fps_cell_model.sv
// Behavioural cell array: stores programmed words, serves reads
`timescale 1ns/1ps
module fps_cell_model
   import fps_pkg::*;
(
   input wire logic clock_i,                         // CPU clock
   input wire fps_pkg::fps_prog_t prog_i,            // Programming command
   input wire logic [fps_pkg::ADDR_W-1:0] addr_i,    // Read byte address
   output logic [fps_pkg::DATA_W-1:0] rdata_o        // Read word
);
   logic [15:0] mem [int];
   logic pulse_q = 1'b0;

   // Cells take the command once, at the start of the pulse
   always @(posedge clock_i) begin
      pulse_q <= prog_i.pulse;
      if (prog_i.pulse && !pulse_q) begin
         if (prog_i.lanes[0]) mem[int'({prog_i.dw_addr, 1'b0})] = prog_i.data[15:0];
         if (prog_i.lanes[1]) mem[int'({prog_i.dw_addr, 1'b1})] = prog_i.data[31:16];
      end
   end

   // Unwritten cells read erased; pulse_q retriggers after a store
   always @(addr_i, pulse_q) begin
      rdata_o = mem.exists(int'(addr_i[17:1])) ? mem[int'(addr_i[17:1])] : 16'hFFFF;
   end
endmodule

// file: verification/fps_top_props.sv
// Port-level assertions for the flash program sequencer
`timescale 1ns/1ps
module fps_top_props
   import fps_pkg::*;
(
   input wire logic clock_i,                              // CPU clock
   input wire logic rstn_i,                               // Reset, active low
   input wire fps_pkg::fps_acc_t acc_i,                   // CPU access
   input wire fps_pkg::fps_rsp_t rsp_o,                   // Answer to the CPU
   input wire logic [fps_pkg::ADDR_W-1:0] array_addr_o,   // Cell read address
   input wire logic [fps_pkg::DATA_W-1:0] array_rdata_i,  // Cell read data
   input wire logic supply_ok_i,                          // Supply pin
   input wire fps_pkg::fps_prog_t prog_o,                 // Programming command
   input wire logic check_margin_o,                       // Check mode
   input wire logic writing_mode_o                        // Writing mode
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   logic in_rng, ctrl_wr, ctrl_rd, cell_wr;

   // Access classes as the sequencer decodes them
   assign in_rng = acc_i.valid && acc_i.addr >= FLASH_FIRST && acc_i.addr <= FLASH_LAST;
   assign ctrl_wr = in_rng && acc_i.write && !acc_i.indirect && !acc_i.addr[0];
   assign ctrl_rd = in_rng && !acc_i.write && !acc_i.indirect && !acc_i.addr[0];
   assign cell_wr = in_rng && acc_i.write && acc_i.indirect;

   // Unlock shape with the single idle cycle the bench leaves between accesses
   sequence unlock_s;
      ctrl_wr && !writing_mode_o ##1 !in_rng ##1 cell_wr && acc_i.wdata == acc_i.addr[15:0];
   endsequence
   // The sync chain has settled long before eight steady cycles are over
   sequence margin_read_s;
      supply_ok_i [*8] ##1 ctrl_rd;
   endsequence
   // Pulse still high a cycle later, so the last pulse cycle never counts
   sequence busy_read_s;
      ctrl_rd && prog_o.pulse ##1 prog_o.pulse;
   endsequence

   access_acked_a: assert property (in_rng |=> rsp_o.ack)
      else $error("In-range access not acknowledged");
   stray_ack_a: assert property (!in_rng |=> !rsp_o.ack)
      else $error("Acknowledge without an access");
   ctrl_no_pulse_a: assert property (ctrl_wr && !prog_o.pulse |=> !prog_o.pulse)
      else $error("Control write started a pulse");
   dword_place_a: assert property ($rose(prog_o.pulse) && prog_o.lanes == 2'b11 |->
      prog_o.data == {$past(acc_i.wdata), $past(acc_i.wdata, 2)} && prog_o.dw_addr == $past(acc_i.addr[17:2]))
      else $error("Doubleword words misplaced");
   busy_ignores_a: assert property (prog_o.pulse && cell_wr |=> $stable(prog_o.data) && $stable(prog_o.dw_addr))
      else $error("Cell write accepted while busy");
   verify_entry_a: assert property ($fell(prog_o.pulse) |-> ##[0:2] check_margin_o)
      else $error("Check mode not entered after pulse");
   busy_shown_a: assert property (busy_read_s |-> rsp_o.data[2])
      else $error("Busy bit low during pulse");
   margin_bit_a: assert property (margin_read_s |=> rsp_o.data[4])
      else $error("Margin bit low with supply good");
   unlock_wait_a: assert property (unlock_s |=> !writing_mode_o [*8] ##[1:300] writing_mode_o)
      else $error("Unlock wait wrong");
   trusted_read_a: assert property (rsp_o.trusted |->
      $past(in_rng && !acc_i.write && acc_i.indirect && check_margin_o))
      else $error("Trusted flag without a check read");
   exit_verify_a: assert property (ctrl_wr && !acc_i.wdata[0] && writing_mode_o && !prog_o.pulse |->
      ##[1:2] !check_margin_o)
      else $error("Check mode kept after enable cleared");
   exit_std_a: assert property (ctrl_wr && acc_i.wdata[15] == 1'b0 && !acc_i.wdata[0] && writing_mode_o &&
      !prog_o.pulse |-> ##[1:2] !writing_mode_o)
      else $error("Writing mode kept after stay bit cleared");
endmodule
